// ===== hgc_bank_ctrl.sv
// Purpose: one bank of general-purpose pins with direction, output and input registers
// Assumes: plain register port, read data one cycle after the read strobe
// Notes:   three instances with different parameters cover the whole pin range
//
// How it works
// R1: first bank owns pins 0..28, second bank owns pins 29..57.
// R2: third bank owns pins 58..70 plus fourteen pins that are input only.
// R3: output data, direction and input level registers, each 32 bits wide.
// R4: direction bit n high makes pin n an output, low an input.
// R5: output data bit n sets the level on pin n while it is output.
// R6: output data one drives high, zero drives low.
// R7: input level read returns present pin states, bit n for pin n.
// R8: in the second bank bit 0 is pin 29, ascending from there.
// R9: second bank direction bits 24 and 25 steer led and button pins.
// R10: second bank output bit 24 sets the user led pin level.
// R11: second bank registers decode in a 4 KB window at 0xff708000.
// R12: third bank registers decode in a 4 KB window at 0xff70a000.
// R13: peripheral register space of the subsystem starts at 0xfc000000.
// R14: writes reach pins at the next edge; inputs synchronised before capture.
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module hgc_bank_ctrl #(
  parameter int unsigned P_IO_PINS   = 29,
  parameter int unsigned P_IN_PINS   = 0,
  parameter int unsigned P_FIRST_PIN = 29,
  parameter logic [31:0] P_BASE_ADDR = 32'hff708000
) (
  // clock and reset
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_arst_n,
  // register port
  input  wire logic [31:0]          i_addr,
  input  wire logic [31:0]          i_wdata,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  output logic      [31:0]          o_rdata,
  output logic                      o_rvalid,
  // two-way pins
  input  wire logic [P_IO_PINS-1:0] i_pin_in,
  output logic      [P_IO_PINS-1:0] o_pin_out,
  output logic      [P_IO_PINS-1:0] o_pin_oe,
  // input-only pins, ignored when the bank has none
  input  wire logic [((P_IN_PINS > 0) ? P_IN_PINS : 1)-1:0] i_gpi
);

  localparam int unsigned SW = P_IO_PINS + P_IN_PINS;

  // R1 R2 bank widths must fit the 32-bit registers
  if (P_IO_PINS < 1 || SW > hgc_pkg::REG_WIDTH) begin : g_bad_width
    $error("hgc_bank_ctrl: pin count does not fit a 32-bit register");
  end
  // R11 R12 window must be 4 KB aligned
  if (P_BASE_ADDR[hgc_pkg::WIN_BITS-1:0] != 12'h000) begin : g_bad_align
    $error("hgc_bank_ctrl: base address not aligned to the window");
  end
  // R13 window must lie in the peripheral space
  if (P_BASE_ADDR < hgc_pkg::PERIPH_BASE) begin : g_bad_base
    $error("hgc_bank_ctrl: base address below peripheral space");
  end
  if (P_FIRST_PIN > 255) begin : g_bad_first
    $error("hgc_bank_ctrl: first pin number too large");
  end

  // R2 only two-way pins get writable bits; input-only pins never drive
  localparam logic [31:0] IO_MASK = 32'((64'h1 << P_IO_PINS) - 64'h1);

  localparam logic [31:0] INFO_VALUE =
    (32'(P_IO_PINS)   << hgc_pkg::INFO_IO_LSB) |
    (32'(P_IN_PINS)   << hgc_pkg::INFO_IN_LSB) |
    (32'(P_FIRST_PIN) << hgc_pkg::INFO_PIN_LSB);

  typedef struct packed {
    logic [31:0] out_data;
    logic [31:0] direction;
    logic [31:0] in_level;
    logic [31:0] rdata;
    logic        rvalid;
  } hgc_bank_state_type;

  hgc_bank_state_type state_q;
  hgc_bank_state_type state_d;

  logic [SW-1:0] sync_in;
  logic [SW-1:0] sync_out;
  logic          hit;
  logic [11:0]   ofs;

  // R2 input-only pins join above the two-way pins
  if (P_IN_PINS > 0) begin : g_with_gpi
    assign sync_in = {i_gpi, i_pin_in};
  end else begin : g_no_gpi
    assign sync_in = i_pin_in;
  end

  // R14 pin levels pass two flops first
  hgc_sync #(
    .W (SW)
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_arst_n  (i_arst_n),
    .i_async   (sync_in),
    .o_sync    (sync_out)
  );

  // R11 R12 decode on the upper address bits only
  assign hit = (i_addr[31:hgc_pkg::WIN_BITS] == P_BASE_ADDR[31:hgc_pkg::WIN_BITS]);
  assign ofs = i_addr[hgc_pkg::WIN_BITS-1:0];

  always_comb begin
    state_d        = state_q;
    state_d.rdata  = 32'h00000000;
    state_d.rvalid = 1'b0;

    // R7 input level captured from synchronised pins
    state_d.in_level          = 32'h00000000;
    state_d.in_level[SW-1:0]  = sync_out;

    // R3 R14 register writes, effective at the next edge
    if (i_wr && hit) begin
      if (ofs == hgc_pkg::OFS_OUT_DATA) begin
        state_d.out_data = i_wdata & IO_MASK;
      end else if (ofs == hgc_pkg::OFS_DIRECTION) begin
        state_d.direction = i_wdata & IO_MASK;
      end else if (ofs == hgc_pkg::OFS_OUT_SET) begin
        // atomic set avoids a read-modify-write race with other software
        state_d.out_data = (state_q.out_data | i_wdata) & IO_MASK;
      end else if (ofs == hgc_pkg::OFS_OUT_CLR) begin
        state_d.out_data = state_q.out_data & ~i_wdata & IO_MASK;
      end
    end

    // reads answer one cycle later; unmapped reads give zero
    if (i_rd) begin
      state_d.rvalid = 1'b1;
      if (!hit) begin
        state_d.rdata = 32'h00000000;
      end else if (ofs == hgc_pkg::OFS_OUT_DATA) begin
        state_d.rdata = state_q.out_data;
      end else if (ofs == hgc_pkg::OFS_DIRECTION) begin
        state_d.rdata = state_q.direction;
      end else if (ofs == hgc_pkg::OFS_IN_LEVEL) begin
        // R7 present level, one bit per pin
        state_d.rdata = state_q.in_level;
      end else if (ofs == hgc_pkg::OFS_BANK_INFO) begin
        state_d.rdata = INFO_VALUE;
      end else begin
        state_d.rdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q           <= '0;
      state_q.out_data  <= hgc_pkg::RST_OUT_DATA;
      state_q.direction <= hgc_pkg::RST_DIRECTION;
    end else begin
      state_q <= state_d;
    end
  end

  // R4 R8 R9 direction bit n enables driver of pin n
  assign o_pin_oe  = state_q.direction[P_IO_PINS-1:0];
  // R5 R6 R10 output bit n is the driven level
  assign o_pin_out = state_q.out_data[P_IO_PINS-1:0];
  assign o_rdata   = state_q.rdata;
  assign o_rvalid  = state_q.rvalid;

endmodule
`default_nettype wire

// ===== hgc_bank_ctrl_assertions.sv
// Purpose: port checks of one pin bank
// Assumes: top ports only
// Notes:   level check waits for quiet pins
`timescale 1ns/10ps
`default_nettype none
module hgc_bank_chk #(
  parameter int unsigned P_IO_PINS   = 29,
  parameter int unsigned P_IN_PINS   = 0,
  parameter logic [31:0] P_BASE_ADDR = 32'hff708000
) (
  input wire logic                 i_ref_clk,
  input wire logic                 i_arst_n,
  input wire logic [31:0]          i_addr,
  input wire logic [31:0]          i_wdata,
  input wire logic                 i_wr,
  input wire logic                 i_rd,
  input wire logic [31:0]          o_rdata,
  input wire logic                 o_rvalid,
  input wire logic [P_IO_PINS-1:0] i_pin_in,
  input wire logic [P_IO_PINS-1:0] o_pin_out,
  input wire logic [P_IO_PINS-1:0] o_pin_oe,
  input wire logic [((P_IN_PINS > 0) ? P_IN_PINS : 1)-1:0] i_gpi
);
  localparam int W = P_IO_PINS;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  wire logic         hit = i_addr[31:12] == P_BASE_ADDR[31:12];
  wire logic [11:0]  ofs = i_addr[11:0];
  wire logic [W-1:0] wlo = i_wdata[W-1:0];
  // synchroniser still clears after reset
  logic [2:0] up_q;
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
    if (!i_arst_n) up_q <= 3'h0;
    else if (up_q != 3'h7) up_q <= up_q + 3'h1;
  sequence pins_quiet;
    $stable(i_pin_in)[*5];
  endsequence
  a_read_answer: assert property (i_rd |=> o_rvalid) else $error("no read answer");
  a_answer_cause: assert property (o_rvalid |-> $past(i_rd)) else $error("stray answer");
  a_rdata_idle: assert property (!o_rvalid |-> o_rdata == 32'h0) else $error("rdata idle");
  a_dir_write: assert property (i_wr && hit && ofs == hgc_pkg::OFS_DIRECTION
    |=> o_pin_oe == $past(wlo)) else $error("direction write");
  a_out_write: assert property (i_wr && hit && ofs == hgc_pkg::OFS_OUT_DATA
    |=> o_pin_out == $past(wlo)) else $error("output write");
  a_pins_hold: assert property (!(i_wr && hit)
    |=> $stable(o_pin_out) && $stable(o_pin_oe)) else $error("pins moved");
  a_dir_readback: assert property (i_rd && hit && ofs == hgc_pkg::OFS_DIRECTION
    |=> o_rdata == 32'($past(o_pin_oe))) else $error("direction read");
  a_level_read: assert property (pins_quiet ##0 (up_q == 3'h7 && i_rd && hit
    && ofs == hgc_pkg::OFS_IN_LEVEL) |=> o_rdata[W-1:0] == $past(i_pin_in))
    else $error("level read");
endmodule
bind hgc_bank_ctrl hgc_bank_chk #(.P_IO_PINS(P_IO_PINS), .P_IN_PINS(P_IN_PINS),
  .P_BASE_ADDR(P_BASE_ADDR)) hgc_bank_chk_inst (.i_ref_clk(i_ref_clk),
  .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_rvalid(o_rvalid), .i_pin_in(i_pin_in), .o_pin_out(o_pin_out),
  .o_pin_oe(o_pin_oe), .i_gpi(i_gpi));
`default_nettype wire

// ===== hgc_bank_ctrl_tb_top.sv
// Purpose: bench of the bank set up as second bank and as third bank
// Assumes: board model drives undriven pins
// Notes:   expectations from an integer model
`timescale 1ns/10ps
`default_nettype none
module hgc_bank_ctrl_tb_top;
  localparam logic [31:0] B = hgc_pkg::BANK1_BASE;
  localparam logic [31:0] B2 = hgc_pkg::BANK2_BASE;
  localparam logic [31:0] D = B + hgc_pkg::OFS_DIRECTION;
  localparam int          M = 32'h1fffffff;
  logic        clk, rvalid, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [31:0] rdata, addr = 32'h0, wdata = 32'h0, ext = 32'h0;
  logic [28:0] pin_in, pin_out, pin_oe;
  logic [31:0] rdata2;
  logic        rvalid2;
  logic [12:0] pin_in2, pin_out2, pin_oe2;
  int          error_cnt, n_checks, cyc, dir, dat, d, o;
  hgc_bank_ctrl hgc_bank_ctrl_inst (.i_ref_clk(clk), .i_arst_n(rst_n), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_rvalid(rvalid),
    .i_pin_in(pin_in), .o_pin_out(pin_out), .o_pin_oe(pin_oe), .i_gpi(1'b0));
  hgc_pins_model #(.W(29)) hgc_pins_model_inst (.i_out(pin_out), .i_oe(pin_oe),
    .i_ext(ext[28:0]), .o_lvl(pin_in));
  // third bank shares the register port; input-only pins come from the board directly
  hgc_bank_ctrl #(.P_IO_PINS(hgc_pkg::BANK2_PINS), .P_IN_PINS(hgc_pkg::BANK2_IN_ONLY),
    .P_FIRST_PIN(hgc_pkg::BANK2_FIRST), .P_BASE_ADDR(B2)) hgc_bank_ctrl_inst2 (
    .i_ref_clk(clk), .i_arst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata2), .o_rvalid(rvalid2), .i_pin_in(pin_in2),
    .o_pin_out(pin_out2), .o_pin_oe(pin_oe2), .i_gpi(ext[26:13]));
  hgc_pins_model #(.W(13)) hgc_pins_model_inst2 (.i_out(pin_out2), .i_oe(pin_oe2),
    .i_ext(ext[12:0]), .o_lvl(pin_in2));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      $display("Error %s expected %h seen %h", n, e, s);
      error_cnt++;
    end
  endtask
  task automatic bus_wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task automatic bus_rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 chk("rdata", rdata, (a[31:12] == B[31:12]) ? e : 32'h0);
    chk("rdata2", rdata2, (a[31:12] == B2[31:12]) ? e : 32'h0);
    chk("rvalid", {30'h0, rvalid, rvalid2}, 32'h3);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      test_done();
    end
  end
  initial begin
    void'($urandom(32'h8772a1cf));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    bus_rd(B, 0);
    bus_rd(D, 0);
    // first pass lights the led and presses the button
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 32'h01000000 : $urandom;
      o = (i == 0) ? 32'h01000000 : $urandom;
      bus_wr(D, d);
      ext <= (i == 0) ? 32'h02000000 : $urandom;
      bus_wr(B, o);
      dir = d & M;
      dat = o & M;
      #1 chk("oe", {3'h0, pin_oe}, dir);
      chk("out", {3'h0, pin_out}, dat);
      bus_rd(D, dir);
      bus_rd(B, dat);
      repeat (4) @(posedge clk);
      bus_rd(B + hgc_pkg::OFS_IN_LEVEL, ((dir & dat) | (~dir & ext)) & M);
    end
    // third bank: set and clear words, input-only pins above the two-way pins
    bus_wr(B2 + hgc_pkg::OFS_DIRECTION, 32'hffffffff);
    bus_wr(B2 + hgc_pkg::OFS_OUT_SET, 32'hffff0f0f);
    bus_wr(B2 + hgc_pkg::OFS_OUT_CLR, 32'h00000303);
    #1 chk("oe2", {19'h0, pin_oe2}, 32'h1fff);
    chk("out2", {19'h0, pin_out2}, 32'h0c0c);
    bus_rd(D, dir);
    bus_rd(B + 32'h100, 0);
    bus_rd(B2 + hgc_pkg::OFS_DIRECTION, 32'h1fff);
    bus_rd(B2 + hgc_pkg::OFS_BANK_INFO, 32'h003a0e0d);
    repeat (4) @(posedge clk);
    bus_rd(B2 + hgc_pkg::OFS_IN_LEVEL, {5'h0, ext[26:13], 13'h0c0c});
    // mid-run reset drops every driver
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    #1 chk("oe", {3'h0, pin_oe}, 0);
    chk("out2", {19'h0, pin_out2}, 0);
    bus_rd(D, 0);
    test_done();
  end
endmodule
`default_nettype wire

// ===== hgc_pins_model.sv
// Purpose: board side of the pins
// Assumes: no pulls on the board
// Notes:   driven pins read back their own level
`timescale 1ns/10ps
`default_nettype none
module hgc_pins_model #(
  parameter int W = 29
) (
  input  wire logic [W-1:0] i_out,
  input  wire logic [W-1:0] i_oe,
  input  wire logic [W-1:0] i_ext,
  output logic      [W-1:0] o_lvl
);
  assign o_lvl = (i_oe & i_out) | (~i_oe & i_ext);
endmodule
`default_nettype wire

// ===== hgc_pkg.sv
// Purpose: shared constants for the pin bank controller
// Assumes: one clock, one asynchronous active-low reset
// Notes:   byte offsets are inside a 4 KB window
package hgc_pkg;

  // address map
  localparam logic [31:0] PERIPH_BASE   = 32'hfc000000;
  localparam logic [31:0] BANK1_BASE    = 32'hff708000;
  localparam logic [31:0] BANK2_BASE    = 32'hff70a000;
  localparam int          WIN_BITS      = 12;
  localparam int          WIN_BYTES     = 4096;

  // register offsets within the window
  localparam logic [11:0] OFS_OUT_DATA  = 12'h000;
  localparam logic [11:0] OFS_DIRECTION = 12'h004;
  localparam logic [11:0] OFS_OUT_SET   = 12'h008;
  localparam logic [11:0] OFS_OUT_CLR   = 12'h00c;
  localparam logic [11:0] OFS_IN_LEVEL  = 12'h050;
  localparam logic [11:0] OFS_BANK_INFO = 12'h054;

  // reset values
  localparam logic [31:0] RST_OUT_DATA  = 32'h00000000;
  localparam logic [31:0] RST_DIRECTION = 32'h00000000;

  // bank info field positions
  localparam int          INFO_IO_LSB   = 0;
  localparam int          INFO_IN_LSB   = 8;
  localparam int          INFO_PIN_LSB  = 16;

  // bank geometry
  localparam int          BANK0_FIRST   = 0;
  localparam int          BANK1_FIRST   = 29;
  localparam int          BANK2_FIRST   = 58;
  localparam int          BANK01_PINS   = 29;
  localparam int          BANK2_PINS    = 13;
  localparam int          BANK2_IN_ONLY = 14;
  localparam int          LED_BIT       = 24;
  localparam int          BUTTON_BIT    = 25;
  localparam int          REG_WIDTH     = 32;

endpackage

// ===== hgc_sync.sv
// Purpose: two-stage synchroniser for pin levels
// Assumes: inputs are asynchronous to i_ref_clk
// Notes:   first stage feeds the second stage only
`timescale 1ns/10ps
`default_nettype none
module hgc_sync #(
  parameter int W = 29
) (
  // clock and reset
  input  wire logic         i_ref_clk,
  input  wire logic         i_arst_n,
  // levels
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } hgc_sync_state_type;

  hgc_sync_state_type state_q;
  hgc_sync_state_type state_d;

  always_comb begin
    state_d        = state_q;
    state_d.meta   = i_async;
    state_d.stable = state_q.meta;
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_sync = state_q.stable;

endmodule
`default_nettype wire
